// ---- rtl/irpc_codec.sv ----
/*
 * Infrared 3/16 pulse encoder and decoder between a UART and a transceiver.
 * Assumes a 40 MHz system clock well above the baud_x16 pin rate; all pins
 * are asynchronous and are synchronised here.
 */
`timescale 1ns/10ps
`include "irpc_cfg.svh"

module irpc_codec
   import irpc_pkg::*;
(
   input wire logic clock, // System clock, 40 MHz
   input wire logic rst_b, // Async reset, active low
   input wire logic baud_x16_clock, // Pin, 16x baud rate
   input wire logic uart_tx_in, // Pin, UART serial output
   input wire logic decoder_reset_n, // Pin, decoder reset, active low
   input wire logic optical_pulse_in, // Pin, transceiver pulse, low active
   output logic optical_pulse_out, // Pulse to transceiver
   output logic decoded_receive_out // Serial data to UART
);

   // ----------------------------------------------------------------
   // Pin synchronisation and tick
   // ----------------------------------------------------------------
   logic [`IRPC_SYNC_W-1:0] pins_w;
   logic [`IRPC_SYNC_W-1:0] sync_w;
   logic baud_prev_r;
   logic tick_w;
   logic tx_w;
   logic opt_w;
   logic dec_en_w;

   assign pins_w = {decoder_reset_n, optical_pulse_in, uart_tx_in, baud_x16_clock};

   irpc_sync u_sync (
      .clock(clock),
      .rst_b(rst_b),
      .pin_in(pins_w),
      .sync_out(sync_w)
   );

   assign tx_w = sync_w[`IRPC_SI_TX];
   assign opt_w = sync_w[`IRPC_SI_OPT];
   assign dec_en_w = sync_w[`IRPC_SI_DRST];

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         baud_prev_r <= 1'b0;
      end else begin
         baud_prev_r <= sync_w[`IRPC_SI_BAUD];
      end
   end

   assign tick_w = sync_w[`IRPC_SI_BAUD] & ~baud_prev_r;

   // ----------------------------------------------------------------
   // Encoder
   // ----------------------------------------------------------------
   irpc_enc_state_t enc_state_r;
   irpc_enc_state_t enc_state_nxt;
   logic [`IRPC_PH_W-1:0] enc_ph_r;
   logic [`IRPC_PH_W-1:0] enc_ph_nxt;
   logic tx_prev_r;
   logic tx_fall_w;
   logic enc_out_nxt;
   logic enc_bit_end_w;

   // Transmit sampled on ticks only, so edges align to the baud grid
   assign tx_fall_w = tick_w & tx_prev_r & ~tx_w;
   // A held-low line is a further zero bit, hence another pulse
   assign enc_bit_end_w = (enc_ph_r == `IRPC_BIT_LAST);

   always_comb begin
      enc_state_nxt = enc_state_r;
      enc_ph_nxt = enc_ph_r;
      unique case (enc_state_r)
         IRPC_ENC_IDLE: begin
            if (tx_fall_w) begin
               enc_state_nxt = IRPC_ENC_BIT;
               enc_ph_nxt = `IRPC_PH_ZERO;
            end
         end
         IRPC_ENC_BIT: begin
            if (tick_w) begin
               enc_ph_nxt = enc_ph_r + `IRPC_PH_ONE;
               if (enc_bit_end_w && tx_w) begin
                  enc_state_nxt = IRPC_ENC_IDLE;
               end
            end
         end
         default: begin
            enc_state_nxt = IRPC_ENC_IDLE;
            enc_ph_nxt = `IRPC_PH_ZERO;
         end
      endcase
   end

   // High on phases 7, 8, 9 of each zero bit
   assign enc_out_nxt = (enc_state_nxt == IRPC_ENC_BIT) &&
                        (enc_ph_nxt >= `IRPC_ENC_ON_PH) &&
                        (enc_ph_nxt < `IRPC_ENC_OFF_PH);

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         enc_state_r <= IRPC_ENC_IDLE;
         enc_ph_r <= `IRPC_PH_ZERO;
         tx_prev_r <= 1'b1;
         optical_pulse_out <= 1'b0;
      end else begin
         enc_state_r <= enc_state_nxt;
         enc_ph_r <= enc_ph_nxt;
         if (tick_w) begin
            tx_prev_r <= tx_w;
         end
         optical_pulse_out <= enc_out_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Decoder
   // ----------------------------------------------------------------
   irpc_dec_state_t dec_state_r;
   irpc_dec_state_t dec_state_nxt;
   logic [`IRPC_PH_W-1:0] dec_cnt_r;
   logic [`IRPC_PH_W-1:0] dec_cnt_nxt;
   logic opt_prev_r;
   logic opt_fall_w;
   logic pend_r;
   logic start_w;
   logic dec_out_nxt;

   // Edge caught at system rate: a short pulse may fall between ticks
   assign opt_fall_w = opt_prev_r & ~opt_w;
   assign start_w = tick_w & pend_r;

   always_comb begin
      dec_state_nxt = dec_state_r;
      dec_cnt_nxt = dec_cnt_r;
      if (start_w) begin
         dec_state_nxt = IRPC_DEC_STRETCH;
         dec_cnt_nxt = `IRPC_PH_ZERO;
      end else if (tick_w) begin
         unique case (dec_state_r)
            IRPC_DEC_IDLE: begin
               dec_cnt_nxt = `IRPC_PH_ZERO;
            end
            IRPC_DEC_STRETCH: begin
               if (dec_cnt_r == `IRPC_BIT_LAST) begin
                  dec_state_nxt = IRPC_DEC_IDLE;
               end else begin
                  dec_cnt_nxt = dec_cnt_r + `IRPC_PH_ONE;
               end
            end
            default: begin
               dec_state_nxt = IRPC_DEC_IDLE;
               dec_cnt_nxt = `IRPC_PH_ZERO;
            end
         endcase
      end
   end

   assign dec_out_nxt = (dec_state_nxt != IRPC_DEC_STRETCH);

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         dec_state_r <= IRPC_DEC_IDLE;
         dec_cnt_r <= `IRPC_PH_ZERO;
         opt_prev_r <= 1'b1;
         pend_r <= 1'b0;
         decoded_receive_out <= 1'b1;
      end else if (!dec_en_w) begin
         dec_state_r <= IRPC_DEC_IDLE;
         dec_cnt_r <= `IRPC_PH_ZERO;
         opt_prev_r <= opt_w;
         pend_r <= 1'b0;
         decoded_receive_out <= 1'b1;
      end else begin
         dec_state_r <= dec_state_nxt;
         dec_cnt_r <= dec_cnt_nxt;
         opt_prev_r <= opt_w;
         // New edge wins over the tick that consumes the old one
         pend_r <= opt_fall_w | (pend_r & ~tick_w);
         decoded_receive_out <= dec_out_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   logic [`IRPC_LOW_W-1:0] low_len_r;

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         low_len_r <= `IRPC_LOW_ZERO;
      end else if (decoded_receive_out) begin
         low_len_r <= `IRPC_LOW_ZERO;
      end else if (tick_w && low_len_r != {`IRPC_LOW_W{1'b1}}) begin
         low_len_r <= low_len_r + `IRPC_LOW_ONE;
      end
   end

   property p_tick_only;
      @(posedge clock) disable iff (!rst_b)
      !tick_w |=> $stable(optical_pulse_out) && $stable(enc_ph_r);
   endproperty
   a_tick_only: assert property (p_tick_only) else $error("encoder moved off tick");

   property p_no_pulse_idle;
      @(posedge clock) disable iff (!rst_b)
      enc_state_r == IRPC_ENC_IDLE |-> !optical_pulse_out;
   endproperty
   a_no_pulse_idle: assert property (p_no_pulse_idle) else $error("pulse outside bit");

   property p_pulse_on;
      @(posedge clock) disable iff (!rst_b)
      $rose(optical_pulse_out) |-> enc_ph_r == `IRPC_ENC_ON_PH && $past(tick_w);
   endproperty
   a_pulse_on: assert property (p_pulse_on) else $error("pulse rose at wrong phase");

   property p_pulse_off;
      @(posedge clock) disable iff (!rst_b)
      $fell(optical_pulse_out) |-> enc_ph_r == `IRPC_ENC_OFF_PH;
   endproperty
   a_pulse_off: assert property (p_pulse_off) else $error("pulse width not three");

   property p_fall_caught;
      @(posedge clock) disable iff (!rst_b)
      dec_en_w && opt_fall_w |=> pend_r || !dec_en_w;
   endproperty
   a_fall_caught: assert property (p_fall_caught) else $error("received edge lost");

   property p_stretch_end;
      @(posedge clock) disable iff (!rst_b)
      $rose(decoded_receive_out) && $past(dec_en_w) |-> $past(dec_cnt_r) == `IRPC_BIT_LAST;
   endproperty
   a_stretch_end: assert property (p_stretch_end) else $error("stretch not 16 ticks");

   property p_low_min;
      @(posedge clock) disable iff (!rst_b)
      $rose(decoded_receive_out) && $past(dec_en_w) |-> $past(low_len_r) >= `IRPC_LOW_MIN;
   endproperty
   a_low_min: assert property (p_low_min) else $error("low interval too short");

   property p_dec_reset;
      @(posedge clock) disable iff (!rst_b)
      !dec_en_w |=> decoded_receive_out && dec_state_r == IRPC_DEC_IDLE && !pend_r;
   endproperty
   a_dec_reset: assert property (p_dec_reset) else $error("decoder active in reset");

   property p_restart;
      @(posedge clock) disable iff (!rst_b)
      dec_en_w && start_w |=> !dec_en_w || (!decoded_receive_out && dec_cnt_r == `IRPC_PH_ZERO);
   endproperty
   a_restart: assert property (p_restart) else $error("stretch not restarted");

endmodule

// ---- rtl/irpc_cfg.svh ----
/*
 * Constants of the infrared pulse codec: bit phases, stretch length,
 * synchroniser reset pattern.
 * Assumes inclusion by its bare name from the codec files.
 */
`ifndef IRPC_CFG_SVH
`define IRPC_CFG_SVH

// ----------------------------------------------------------------
// Encoder phases, counted in baud_x16 ticks from the falling edge
// ----------------------------------------------------------------
`define IRPC_PH_W 4
`define IRPC_PH_ZERO 4'h0
`define IRPC_PH_ONE 4'h1
`define IRPC_ENC_ON_PH 4'h7
`define IRPC_ENC_OFF_PH 4'hA
`define IRPC_BIT_LAST 4'hF

// ----------------------------------------------------------------
// Decoder stretch
// ----------------------------------------------------------------
`define IRPC_LOW_W 5
`define IRPC_LOW_ZERO 5'h00
`define IRPC_LOW_ONE 5'h01
`define IRPC_LOW_MIN 5'h0C

// ----------------------------------------------------------------
// Pin synchroniser: [0] baud clock, [1] tx, [2] optical in, [3] dec reset
// ----------------------------------------------------------------
`define IRPC_SYNC_W 4
`define IRPC_SYNC_RST 4'h6
`define IRPC_SI_BAUD 0
`define IRPC_SI_TX 1
`define IRPC_SI_OPT 2
`define IRPC_SI_DRST 3

`endif

// ---- rtl/irpc_pkg.sv ----
/*
 * Types of the infrared pulse codec: state encodings of both machines.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package irpc_pkg;

   typedef enum logic [1:0] {
      IRPC_ENC_IDLE = 2'b01,
      IRPC_ENC_BIT  = 2'b10
   } irpc_enc_state_t;

   typedef enum logic [1:0] {
      IRPC_DEC_IDLE    = 2'b01,
      IRPC_DEC_STRETCH = 2'b10
   } irpc_dec_state_t;

endpackage

// ---- rtl/irpc_sync.sv ----
/*
 * Bank of two-stage synchronisers for the codec's pin inputs.
 * Assumes asynchronous pins and one system clock; reset pattern per bit.
 */
`timescale 1ns/10ps
`include "irpc_cfg.svh"

module irpc_sync #(
   parameter int W = `IRPC_SYNC_W,
   parameter logic [W-1:0] RST_VAL = `IRPC_SYNC_RST
) (
   input wire logic clock, // System clock
   input wire logic rst_b, // Async reset, active low
   input wire logic [W-1:0] pin_in, // Raw pins
   output logic [W-1:0] sync_out // Synchronised levels
);

   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         logic meta_r;
         logic stab_r;
         // First stage feeds only the second
         always_ff @(posedge clock or negedge rst_b) begin
            if (!rst_b) begin
               meta_r <= RST_VAL[i];
               stab_r <= RST_VAL[i];
            end else begin
               meta_r <= pin_in[i];
               stab_r <= meta_r;
            end
         end
         assign sync_out[i] = stab_r;
      end
   endgenerate

endmodule

// ---- dv/irpc_far_end.sv ----
/*
 * Far-side model of the infrared pulse codec: the UART's 16x baud clock
 * and serial output, and the optical transceiver's received pulses.
 * Assumes the system clock of the codec and a bench that calls its tasks.
 */
`timescale 1ns/10ps

module irpc_far_end #(
   parameter int HALF = 11
) (
   input wire logic clock, // System clock
   output logic baud_x16_clock, // 16x baud clock to the codec
   output logic uart_tx_in, // UART serial output, idle high
   output logic optical_pulse_in // Transceiver pulse, low active
);
   int div;

   initial begin
      baud_x16_clock = 1'b0;
      uart_tx_in = 1'b1;
      optical_pulse_in = 1'b1;
      div = 0;
   end

   // ------------------------------------------------------------
   // Baud clock, free running like the UART's own output
   // ------------------------------------------------------------
   // 22 system clocks a period keeps it below 1.8432 MHz
   always @(posedge clock) begin
      div = (div == HALF - 1) ? 0 : div + 1;
      if (div == 0) baud_x16_clock <= #2 ~baud_x16_clock;
   end

   // ------------------------------------------------------------
   // Serial bits, LSB first, 16 baud ticks each
   // ------------------------------------------------------------
   // Bits change mid-tick so the codec never samples a moving line
   task automatic send_bits(input logic [9:0] bits, input int n);
      for (int i = 0; i < n; i++) begin
         @(negedge baud_x16_clock);
         uart_tx_in = bits[i];
         repeat (15) @(negedge baud_x16_clock);
      end
      @(negedge baud_x16_clock);
      uart_tx_in = 1'b1;
   endtask

   // ------------------------------------------------------------
   // One 3/16 received pulse, then gap idle ticks
   // ------------------------------------------------------------
   task automatic ir_pulse(input int gap);
      @(negedge baud_x16_clock);
      optical_pulse_in = 1'b0;
      repeat (3) @(negedge baud_x16_clock);
      optical_pulse_in = 1'b1;
      repeat (gap) @(negedge baud_x16_clock);
   endtask
endmodule

// ---- dv/tb_top.sv ----
/*
 * Self-checking bench of the infrared pulse codec with its far-side model.
 * Assumes the codec's assertions live in its own files.
 */
`timescale 1ns/10ps

module tb_top;
   localparam int TICK = 22;
   logic clock, rst_b, decoder_reset_n;
   logic baud_x16_clock, uart_tx_in, optical_pulse_in;
   logic optical_pulse_out, decoded_receive_out;
   logic tx_q;
   int fails, check_count, cyc, hi_len, lo_len, pulses, lows, last_hi, last_lo, delay, fall_cyc;

   irpc_codec u_dut (.clock(clock), .rst_b(rst_b), .baud_x16_clock(baud_x16_clock),
      .uart_tx_in(uart_tx_in), .decoder_reset_n(decoder_reset_n),
      .optical_pulse_in(optical_pulse_in), .optical_pulse_out(optical_pulse_out),
      .decoded_receive_out(decoded_receive_out));

   irpc_far_end #(.HALF(TICK / 2)) u_far (.clock(clock), .baud_x16_clock(baud_x16_clock),
      .uart_tx_in(uart_tx_in), .optical_pulse_in(optical_pulse_in));

   // ------------------------------------------------------------
   // Pulse monitor, sampled mid-cycle where outputs are settled
   // ------------------------------------------------------------
   always @(negedge clock) begin
      cyc++;
      if (optical_pulse_out === 1'b1) begin
         if (hi_len == 0) delay = cyc - fall_cyc;
         hi_len++;
      end else if (hi_len > 0) begin
         pulses++;
         last_hi = hi_len;
         hi_len = 0;
      end
      if (decoded_receive_out === 1'b0) lo_len++;
      else if (lo_len > 0) begin
         lows++;
         last_lo = lo_len;
         lo_len = 0;
      end
      if (tx_q === 1'b1 && uart_tx_in === 1'b0) fall_cyc = cyc;
      tx_q = uart_tx_in;
   end

   // ------------------------------------------------------------
   // Shared helpers
   // ------------------------------------------------------------
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         fails++;
         $display("Error: %s expected %0h seen %0h", what, exp, seen);
      end
   endtask

   task automatic tally_and_finish();
      $display("Checks %0d, mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   task automatic clr();
      pulses = 0;
      lows = 0;
   endtask

   // Bounded: both outputs idle for 400 cycles, longer than a 16-tick stretch
   task automatic wait_quiet();
      int q;
      q = 0;
      for (int i = 0; i < 20000 && q < 400; i++) begin
         @(negedge clock);
         q = (hi_len == 0 && lo_len == 0) ? q + 1 : 0;
      end
      if (q < 400) begin
         fails++;
         $display("Error: outputs never settled");
         tally_and_finish();
      end
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_single_zero();
      clr();
      u_far.send_bits(10'h000, 1);
      wait_quiet();
      check("enc_pulses", pulses, 1);
      check("enc_high_width", last_hi, 3 * TICK);
      check("enc_delay_ok", 32'(delay >= 160 && delay <= 180), 1);
   endtask

   // Start bit, data LSB first, stop bit; repeated zeros each pulse
   task automatic t_frames();
      logic [7:0] data [3];
      int zeros [3];
      data = '{8'hA5, 8'h00, 8'hFF};
      zeros = '{5, 9, 1};
      for (int k = 0; k < 3; k++) begin
         clr();
         u_far.send_bits({1'b1, data[k], 1'b0}, 10);
         wait_quiet();
         check("frame_pulses", pulses, zeros[k]);
         check("frame_width", last_hi, 3 * TICK);
      end
   endtask

   task automatic t_rx_pulse();
      clr();
      u_far.ir_pulse(0);
      wait_quiet();
      check("rx_lows", lows, 1);
      check("rx_low_width", last_lo, 16 * TICK);
      check("rx_low_long", 32'(last_lo >= 12 * TICK), 1);
      check("rx_idle", decoded_receive_out, 1);
   endtask

   // Second pulse eight ticks in stretches the low to 24 ticks
   task automatic t_rx_restart();
      clr();
      u_far.ir_pulse(4);
      u_far.ir_pulse(0);
      wait_quiet();
      check("restart_lows", lows, 1);
      check("restart_width", last_lo, 24 * TICK);
   endtask

   task automatic t_dec_reset();
      @(posedge clock) #2 decoder_reset_n = 1'b0;
      repeat (4) @(posedge clock);
      clr();
      u_far.ir_pulse(0);
      u_far.send_bits(10'h000, 1);
      wait_quiet();
      check("blocked_lows", lows, 0);
      check("enc_in_dec_reset", pulses, 1);
      @(posedge clock) #2 decoder_reset_n = 1'b1;
      repeat (4) @(posedge clock);
      u_far.ir_pulse(2);
      check("rx_after_release", decoded_receive_out, 0);
      @(posedge clock) #2 decoder_reset_n = 1'b0;
      repeat (6) @(negedge clock);
      check("rx_cut_by_reset", decoded_receive_out, 1);
      @(posedge clock) #2 decoder_reset_n = 1'b1;
      wait_quiet();
   endtask

   // Second async reset in mid-stretch
   task automatic t_mid_reset();
      u_far.ir_pulse(2);
      @(posedge clock) #2 rst_b = 1'b0;
      @(negedge clock);
      check("rx_in_reset", decoded_receive_out, 1);
      check("tx_in_reset", optical_pulse_out, 0);
      @(posedge clock) #2 rst_b = 1'b1;
      wait_quiet();
   endtask

   // ------------------------------------------------------------
   // Clock, reset and main sequence
   // ------------------------------------------------------------
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end

   initial begin
      rst_b = 1'b0;
      decoder_reset_n = 1'b1;
      tx_q = 1'b1;
      {fails, check_count, cyc, hi_len, lo_len, pulses, lows} = '0;
      {last_hi, last_lo, delay, fall_cyc} = '0;
      repeat (8) @(posedge clock);
      #2 rst_b = 1'b1;
      repeat (4) @(negedge clock);
      check("idle_out", optical_pulse_out, 0);
      check("idle_rx", decoded_receive_out, 1);
      t_single_zero();
      t_frames();
      t_rx_pulse();
      t_rx_restart();
      t_dec_reset();
      t_mid_reset();
      t_rx_pulse();
      tally_and_finish();
   end
endmodule
